// [rtc_port_pkg.sv]
// Package for the host-side controller of the clock chip's asynchronous byte port
`default_nettype none

package rtc_port_pkg;

	// ***************************************************************
	// Clock rate and grade timing, in ns as printed
	// ***************************************************************
	localparam int CLK_PERIOD_NS = 10;
	// Fast grade
	localparam int FAST_CYCLE_TIME_NS = 70;
	localparam int FAST_INDEX_ACCESS_TIME_NS = 70;
	localparam int FAST_SELECT_ACCESS_TIME_NS = 70;
	localparam int FAST_GATE_ACCESS_TIME_NS = 25;
	localparam int FAST_SELECT_TO_FLOAT_TIME_NS = 20;
	localparam int FAST_STROBE_TO_FLOAT_TIME_NS = 20;
	localparam int FAST_STROBE_PULSE_WIDTH_NS = 45;
	localparam int FAST_SELECT_PULSE_WIDTH_NS = 50;
	localparam int FAST_DATA_SETUP_TIME_NS = 25;
	localparam int FAST_INDEX_SETUP_TO_END_NS = 55;
	// Slow grade
	localparam int SLOW_CYCLE_TIME_NS = 85;
	localparam int SLOW_INDEX_ACCESS_TIME_NS = 85;
	localparam int SLOW_SELECT_ACCESS_TIME_NS = 85;
	localparam int SLOW_GATE_ACCESS_TIME_NS = 35;
	localparam int SLOW_SELECT_TO_FLOAT_TIME_NS = 25;
	localparam int SLOW_STROBE_TO_FLOAT_TIME_NS = 25;
	localparam int SLOW_STROBE_PULSE_WIDTH_NS = 55;
	localparam int SLOW_SELECT_PULSE_WIDTH_NS = 60;
	localparam int SLOW_DATA_SETUP_TIME_NS = 30;
	localparam int SLOW_INDEX_SETUP_TO_END_NS = 65;

	// ***************************************************************
	// Cycle counts, least times rounded up
	// ***************************************************************
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cycles

	// Strobe-low phase must cover strobe and select pulse widths and index setup
	function automatic int max3(input int a, input int b, input int c);
		int m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction : max3

	localparam int CNT_W = 4;
	// Write: select+strobe low phase
	localparam logic [CNT_W-1:0] FAST_WR_CYC = CNT_W'(ns_to_cycles(max3(
		FAST_STROBE_PULSE_WIDTH_NS, FAST_SELECT_PULSE_WIDTH_NS, FAST_INDEX_SETUP_TO_END_NS)));
	localparam logic [CNT_W-1:0] SLOW_WR_CYC = CNT_W'(ns_to_cycles(max3(
		SLOW_STROBE_PULSE_WIDTH_NS, SLOW_SELECT_PULSE_WIDTH_NS, SLOW_INDEX_SETUP_TO_END_NS)));
	// Read: wait for data from select/gate fall (index set up one cycle before)
	localparam logic [CNT_W-1:0] FAST_RD_CYC = CNT_W'(ns_to_cycles(max3(
		FAST_INDEX_ACCESS_TIME_NS, FAST_SELECT_ACCESS_TIME_NS, FAST_GATE_ACCESS_TIME_NS)));
	localparam logic [CNT_W-1:0] SLOW_RD_CYC = CNT_W'(ns_to_cycles(max3(
		SLOW_INDEX_ACCESS_TIME_NS, SLOW_SELECT_ACCESS_TIME_NS, SLOW_GATE_ACCESS_TIME_NS)));
	// Recovery: bus float after select rises, and whole cycle time
	localparam logic [CNT_W-1:0] FAST_REC_CYC = CNT_W'(ns_to_cycles(
		FAST_SELECT_TO_FLOAT_TIME_NS));
	localparam logic [CNT_W-1:0] SLOW_REC_CYC = CNT_W'(ns_to_cycles(
		SLOW_SELECT_TO_FLOAT_TIME_NS));
	localparam logic [CNT_W-1:0] FAST_MIN_CYC = CNT_W'(ns_to_cycles(FAST_CYCLE_TIME_NS));
	localparam logic [CNT_W-1:0] SLOW_MIN_CYC = CNT_W'(ns_to_cycles(SLOW_CYCLE_TIME_NS));

	// ***************************************************************
	// Widths and types
	// ***************************************************************
	localparam int INDEX_W = 4;
	localparam int DATA_W = 8;

	typedef struct packed {
		logic write;
		logic to_sram;
		logic [INDEX_W-1:0] reg_index;
		logic [DATA_W-1:0] wdata;
	} req_s;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETUP = 5'h02,
		ST_ACTIVE = 5'h04,
		ST_END = 5'h08,
		ST_RECOVER = 5'h10
	} port_state_e;

endpackage : rtc_port_pkg

`default_nettype wire

// [rtc_host_port.sv]
// Host-side controller that drives reads and writes on the clock chip's byte port
`default_nettype none

// Summary of operation
// R1 - Device reads while strobe high and register select low.
// R2 - Four-bit index chooses one of sixteen registers, 0h to Fh.
// R3 - Read data valid within index access time: 70 or 85 ns.
// R4 - Late select or gate: data valid from later edge, gate 25 or 35 ns.
// R5 - SRAM select low with register select high addresses external SRAM.
// R6 - Host never drives register select and SRAM select low together.
// R7 - Write happens only with strobe and select low after index stable.
// R8 - Write starts at later falling edge, ends at earlier rising edge.
// R9 - Host holds the index steady through the whole write.
// R10 - Host returns select or strobe high for recovery; cycle 70 or 85 ns.
// R11 - Write data valid 25 or 30 ns before ending edge, held to it.
// R12 - Host keeps output gate high during writes.
// R13 - Falling strobe during active read turns outputs off within 20 or 25 ns.
// R14 - Select low during write stores the byte into the indexed register.
// R15 - Strobe-controlled write holds strobe low 45 or 55 ns.
// R16 - Select-controlled write holds select low 50 or 60 ns.
// R17 - Index valid 55 or 65 ns before the terminating rising edge.
// R18 - Device floats data lines within 20 or 25 ns after select rises.
// R19 - Sequence: index, select, gate or strobe, release, recover; cycles round up.
module rtc_host_port #(
	parameter bit SLOW_GRADE = 1'b0
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// User request
	input wire logic req_valid_i,
	input wire rtc_port_pkg::req_s req_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [rtc_port_pkg::DATA_W-1:0] rd_data_o,
	// Device pins
	output logic reg_select_n_o,
	output logic sram_select_n_o,
	output logic gate_n_o,
	output logic store_n_o,
	output logic [rtc_port_pkg::INDEX_W-1:0] reg_index_o,
	input wire logic [rtc_port_pkg::DATA_W-1:0] bus_lines_i,
	output logic [rtc_port_pkg::DATA_W-1:0] bus_lines_o,
	output logic bus_lines_oe_n_o
);

	// ***************************************************************
	// Grade-dependent counts
	// ***************************************************************
	localparam logic [rtc_port_pkg::CNT_W-1:0] WR_CYC =
		SLOW_GRADE ? rtc_port_pkg::SLOW_WR_CYC : rtc_port_pkg::FAST_WR_CYC;
	localparam logic [rtc_port_pkg::CNT_W-1:0] RD_CYC =
		SLOW_GRADE ? rtc_port_pkg::SLOW_RD_CYC : rtc_port_pkg::FAST_RD_CYC;
	localparam logic [rtc_port_pkg::CNT_W-1:0] REC_CYC =
		SLOW_GRADE ? rtc_port_pkg::SLOW_REC_CYC : rtc_port_pkg::FAST_REC_CYC;
	localparam logic [rtc_port_pkg::CNT_W-1:0] MIN_CYC =
		SLOW_GRADE ? rtc_port_pkg::SLOW_MIN_CYC : rtc_port_pkg::FAST_MIN_CYC;

	// ***************************************************************
	// State
	// ***************************************************************
	rtc_port_pkg::port_state_e state_ff;
	rtc_port_pkg::port_state_e nxt_state;
	rtc_port_pkg::req_s req_ff;
	logic [rtc_port_pkg::CNT_W-1:0] cnt_ff;
	logic [rtc_port_pkg::CNT_W-1:0] nxt_cnt;
	logic [rtc_port_pkg::CNT_W-1:0] cyc_ff;
	logic [rtc_port_pkg::DATA_W-1:0] bus_meta_ff;
	logic [rtc_port_pkg::DATA_W-1:0] bus_sync_ff;
	logic active_done;
	logic recover_done;

	// Phase and whole-cycle completion
	// Reads wait one more cycle: data valid on the edge itself is not caught cleanly
	assign active_done = (cnt_ff == (req_ff.write ? WR_CYC + rtc_port_pkg::CNT_W'(2)
		: RD_CYC + rtc_port_pkg::CNT_W'(3))); // R15 R16
	assign recover_done = (cnt_ff >= REC_CYC) && (cyc_ff >= MIN_CYC); // R10

	// Next state and phase counter
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff + rtc_port_pkg::CNT_W'(1);
		case (state_ff)
			rtc_port_pkg::ST_IDLE: begin
				nxt_cnt = '0;
				if (req_valid_i) begin
					nxt_state = rtc_port_pkg::ST_SETUP;
				end
			end
			rtc_port_pkg::ST_SETUP: begin
				// Index settles one cycle before the select falls
				nxt_cnt = '0;
				nxt_state = rtc_port_pkg::ST_ACTIVE; // R19
			end
			rtc_port_pkg::ST_ACTIVE: begin
				// Extra cycles cover read-data synchroniser and capture
				if (active_done) begin
					nxt_state = rtc_port_pkg::ST_END;
				end
			end
			rtc_port_pkg::ST_END: begin
				nxt_cnt = '0;
				nxt_state = rtc_port_pkg::ST_RECOVER;
			end
			rtc_port_pkg::ST_RECOVER: begin
				if (recover_done) begin
					nxt_state = rtc_port_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = rtc_port_pkg::ST_IDLE;
				nxt_cnt = '0;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= rtc_port_pkg::ST_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// Whole-cycle counter from index change, saturating
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cyc_ff <= '0;
		end else if (state_ff == rtc_port_pkg::ST_SETUP) begin
			cyc_ff <= rtc_port_pkg::CNT_W'(1);
		end else if (cyc_ff != '1) begin
			cyc_ff <= cyc_ff + rtc_port_pkg::CNT_W'(1); // R10
		end
	end

	// Request capture, held steady for the whole access
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_ff <= '0;
		end else if (state_ff == rtc_port_pkg::ST_IDLE && req_valid_i) begin
			req_ff <= req_i; // R9
		end
	end

	// Handshake toward the user
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_ready_o <= 1'b0;
		end else begin
			req_ready_o <= (nxt_state == rtc_port_pkg::ST_IDLE);
		end
	end

	// ***************************************************************
	// Pin drive
	// ***************************************************************
	// Selects: only one of the two goes low per access
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_select_n_o <= 1'b1;
			sram_select_n_o <= 1'b1;
		end else begin
			reg_select_n_o <= !(nxt_state == rtc_port_pkg::ST_ACTIVE && !req_ff.to_sram); // R6
			sram_select_n_o <= !(nxt_state == rtc_port_pkg::ST_ACTIVE && req_ff.to_sram); // R5
		end
	end

	// Gate low only for reads, strobe low only for writes
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gate_n_o <= 1'b1;
			store_n_o <= 1'b1;
		end else begin
			gate_n_o <= !(nxt_state == rtc_port_pkg::ST_ACTIVE && !req_ff.write); // R12
			store_n_o <= !(nxt_state == rtc_port_pkg::ST_ACTIVE && req_ff.write); // R7
		end
	end

	// Index set in setup and held until recovery ends
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_index_o <= '0;
		end else if (state_ff == rtc_port_pkg::ST_IDLE && req_valid_i) begin
			reg_index_o <= req_i.reg_index; // R17
		end
	end

	// Write data driven from the select fall until one cycle after the select and strobe rise together
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_lines_o <= '0;
			bus_lines_oe_n_o <= 1'b1;
		end else begin
			bus_lines_o <= req_ff.wdata;
			bus_lines_oe_n_o <= !(req_ff.write && (nxt_state == rtc_port_pkg::ST_ACTIVE
				|| nxt_state == rtc_port_pkg::ST_END)); // R11
		end
	end

	// ***************************************************************
	// Read data capture
	// ***************************************************************
	// Two-flop synchroniser on the data lines
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_meta_ff <= '0;
			bus_sync_ff <= '0;
		end else begin
			bus_meta_ff <= bus_lines_i;
			bus_sync_ff <= bus_meta_ff;
		end
	end

	// Sample at the end of the access window, pulse valid
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= '0;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			if (state_ff == rtc_port_pkg::ST_ACTIVE && active_done && !req_ff.write) begin
				rd_data_o <= bus_sync_ff; // R3 R4
				rd_valid_o <= 1'b1;
			end
		end
	end

endmodule : rtc_host_port

`default_nettype wire

// [rtc_host_port_assertions.sv]
// Bound checker for the host port controller pin timing
`default_nettype none
module rtc_host_port_checker #(
	parameter bit SLOW_GRADE = 1'b0
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Observed outputs
	input wire logic req_ready_o,
	input wire logic reg_select_n_o,
	input wire logic sram_select_n_o,
	input wire logic gate_n_o,
	input wire logic store_n_o,
	input wire logic [3:0] reg_index_o,
	input wire logic [7:0] bus_lines_o,
	input wire logic bus_lines_oe_n_o
);
	// ***************************************************************
	// Pin relations
	// ***************************************************************
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_one_select: assert property (!(!reg_select_n_o && !sram_select_n_o))
		else $error("both selects low");
	a_gate_no_store: assert property (!(!gate_n_o && !store_n_o))
		else $error("gate low during write");
	a_store_selected: assert property (!store_n_o |-> !reg_select_n_o || !sram_select_n_o)
		else $error("strobe without select");
	a_index_steady: assert property ((!reg_select_n_o || !sram_select_n_o) |-> $stable(reg_index_o))
		else $error("index moved in access");
	a_strobe_width: assert property ($fell(store_n_o) |-> !store_n_o [*5])
		else $error("strobe pulse short");
	a_select_width: assert property ($fell(reg_select_n_o) |-> !reg_select_n_o [*5])
		else $error("select pulse short");
	a_data_setup: assert property ($rose(store_n_o) |-> !$past(bus_lines_oe_n_o, 3))
		else $error("write data setup short");
	a_data_hold: assert property ($rose(store_n_o) |-> !bus_lines_oe_n_o && $stable(bus_lines_o))
		else $error("write data not held");
	a_recovery: assert property ($rose(reg_select_n_o) |-> reg_select_n_o [*2])
		else $error("recovery short");
	a_ready_idle: assert property (req_ready_o |-> reg_select_n_o && sram_select_n_o && store_n_o)
		else $error("ready during access");
	a_drive_no_gate: assert property (!bus_lines_oe_n_o |-> gate_n_o)
		else $error("host drives in read");
endmodule : rtc_host_port_checker

bind rtc_host_port rtc_host_port_checker #(.SLOW_GRADE(SLOW_GRADE)) i_rtc_host_port_checker (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_ready_o(req_ready_o),
	.reg_select_n_o(reg_select_n_o), .sram_select_n_o(sram_select_n_o), .gate_n_o(gate_n_o),
	.store_n_o(store_n_o), .reg_index_o(reg_index_o), .bus_lines_o(bus_lines_o),
	.bus_lines_oe_n_o(bus_lines_oe_n_o));
`default_nettype wire

// [rtc_device_model.sv]
// Behavioural clock chip byte port with sixteen registers and a small SRAM
`default_nettype none
module rtc_device_model (
	// Host pins
	input wire logic reg_select_n_i,
	input wire logic sram_select_n_i,
	input wire logic gate_n_i,
	input wire logic store_n_i,
	input wire logic [3:0] reg_index_i,
	input wire logic [7:0] bus_i,
	// Device data
	output logic [7:0] q_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [16];
	logic [7:0] sram [16];
	logic rd_on, wr_reg, wr_ram;
	initial q_o = 8'h5a;
	// Read while strobe high with a select and gate low
	assign rd_on = store_n_i && !gate_n_i && !(reg_select_n_i && sram_select_n_i);
	// Write spans later fall to earlier rise
	assign wr_reg = !store_n_i && !reg_select_n_i;
	assign wr_ram = !store_n_i && !sram_select_n_i && reg_select_n_i;
	// Byte stored at write end
	always @(negedge wr_reg) regs[reg_index_i] = bus_i;
	always @(negedge wr_ram) sram[reg_index_i] = bus_i;
	// Drive after fast-grade index access time, released lines show inverted junk
	always @(rd_on or reg_index_i) begin
		if (rd_on)
			q_o <= #(rtc_port_pkg::FAST_INDEX_ACCESS_TIME_NS)
				reg_select_n_i ? sram[reg_index_i] : regs[reg_index_i];
		else
			q_o <= #(rtc_port_pkg::FAST_SELECT_TO_FLOAT_TIME_NS) ~q_o;
	end
endmodule : rtc_device_model
`default_nettype wire

// [test_rtc_host_port.sv]
// Self-checking bench for the host-side clock chip port controller
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module test_rtc_host_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	rtc_port_pkg::req_s req_i = '0;
	logic req_ready_o, rd_valid_o, reg_select_n_o, sram_select_n_o, gate_n_o, store_n_o;
	logic bus_lines_oe_n_o;
	logic [7:0] rd_data_o, bus_lines_o, dev_q, bus_lines_i, q;
	logic [3:0] reg_index_o;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int gap = 99;
	logic sel_idle_q = 1'b1;
	// ***************************************************************
	// Design, device and wiring
	// ***************************************************************
	assign bus_lines_i = bus_lines_oe_n_o ? dev_q : bus_lines_o;
	rtc_host_port #(.SLOW_GRADE(1'b0)) i_rtc_host_port (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .reg_select_n_o(reg_select_n_o),
		.sram_select_n_o(sram_select_n_o), .gate_n_o(gate_n_o), .store_n_o(store_n_o),
		.reg_index_o(reg_index_o), .bus_lines_i(bus_lines_i), .bus_lines_o(bus_lines_o),
		.bus_lines_oe_n_o(bus_lines_oe_n_o));
	rtc_device_model i_rtc_device_model (.reg_select_n_i(reg_select_n_o),
		.sram_select_n_i(sram_select_n_o), .gate_n_i(gate_n_o), .store_n_i(store_n_o),
		.reg_index_i(reg_index_o), .bus_i(bus_lines_i), .q_o(dev_q));
	// Clock
	always #5 mclk_i = ~mclk_i;
	// Cycle ceiling and access spacing
	always @(posedge mclk_i) begin
		cyc++;
		gap++;
		if (reset_n_i && sel_idle_q && !(reg_select_n_o & sram_select_n_o)) begin
			`CHK(gap >= int'(rtc_port_pkg::FAST_MIN_CYC), 1'b1)
			gap = 0;
		end
		sel_idle_q = reg_select_n_o & sram_select_n_o;
		if (cyc == 5000) begin
			n_mismatch++;
			close_out();
		end
	end
	// One access, read byte left in q
	task automatic xfer(input logic w, input logic s, input logic [3:0] ix, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		req_i = '{write: w, to_sram: s, reg_index: ix, wdata: d};
		req_valid_i = 1'b1;
		@(negedge mclk_i);
		req_valid_i = 1'b0;
		n = 0;
		while (!w && rd_valid_o !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		q = rd_data_o;
	endtask : xfer
	// All sixteen registers written then read back
	task automatic t_regs;
		for (int i = 0; i < 16; i++)
			xfer(1'b1, 1'b0, 4'(i), 8'hc3 ^ 8'(i * 17));
		for (int i = 0; i < 16; i++) begin
			xfer(1'b0, 1'b0, 4'(i), 8'h00);
			`CHK(q, 8'hc3 ^ 8'(i * 17))
		end
	endtask : t_regs
	// SRAM kept apart from the registers
	task automatic t_sram;
		xfer(1'b1, 1'b1, 4'h5, 8'ha5);
		xfer(1'b0, 1'b1, 4'h5, 8'h00);
		`CHK(q, 8'ha5)
		xfer(1'b0, 1'b0, 4'h5, 8'h00);
		`CHK(q, 8'hc3 ^ 8'h55)
	endtask : t_sram
	// Write then read straight after, one-cycle read flag
	task automatic t_b2b;
		xfer(1'b1, 1'b0, 4'hf, 8'h3c);
		xfer(1'b0, 1'b0, 4'hf, 8'h00);
		`CHK(q, 8'h3c)
		@(negedge mclk_i);
		`CHK(rd_valid_o, 1'b0)
	endtask : t_b2b
	// Verdict
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Main sequence
	initial begin
		repeat (8) @(negedge mclk_i);
		`CHK({reg_select_n_o, sram_select_n_o, gate_n_o, store_n_o, req_ready_o}, 5'h1e)
		reset_n_i = 1'b1;
		t_regs();
		t_sram();
		t_b2b();
		close_out();
	end
endmodule : test_rtc_host_port
`default_nettype wire
